// *** include/fsra_pkg.sv ***
// Shared constants and types for the flash status register access block
package fsra_pkg;
  localparam logic [7:0] FSRA_OP_READ_SUSPEND = 8'h09;
  localparam logic [7:0] FSRA_OP_WRITE_MAIN   = 8'h01;
  localparam logic [7:0] FSRA_OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] FSRA_OP_FOUR_WIRE    = 8'h38;
  localparam logic [7:0] FSRA_OP_LEAVE_FOUR   = 8'hFF;
  // Suspend status bit positions
  localparam int FSRA_SS_BUSY  = 7;
  localparam int FSRA_SS_FAIL  = 5;
  localparam int FSRA_SS_PROG  = 3;
  localparam int FSRA_SS_ERASE = 2;
  localparam int FSRA_SS_UNLK  = 1;
  // Main status bit positions
  localparam int FSRA_MS_LOCK  = 7;
  localparam int FSRA_MS_GUARD = 2;
  localparam logic [7:0] FSRA_MAIN_RESET = 8'h00;
  // Write cycle time in ns, and suspend/resume cycle time in ns
  localparam int FSRA_T_W_NS      = 10000;
  localparam int FSRA_T_SUSP_NS   = 1000;
  localparam int FSRA_CLK_NS      = 25;
  localparam int FSRA_T_W_CYC     = FSRA_T_W_NS / FSRA_CLK_NS;
  localparam int FSRA_T_SUSP_CYC  = FSRA_T_SUSP_NS / FSRA_CLK_NS;

  typedef struct packed {
    logic busy;
    logic fail;
    logic prog_paused;
    logic erase_paused;
    logic unlock;
  } fsra_flags_t;

  typedef enum logic [1:0] {
    FSRA_OP_IDLE, FSRA_OP_CMD, FSRA_OP_RDSUS, FSRA_OP_WRDATA
  } fsra_phase_t;
endpackage

// *** logic/fsra_core.sv ***
// Serial status register access engine of the flash device
//
// Behaviour
// - Opcode 09h shifts out suspend status anytime
// - Suspend status repeats while select low
// - Suspend bit 7 equals main busy bit
// - Reserved suspend bits read zero
// - Bit 1 mirrors latch; gates suspend/resume
// - Erase paused flag set/cleared by suspend/resume
// - Program paused flag set/cleared by suspend/resume
// - Fail flag latches; clears on new cycle/reset
// - Volatile flags zero after power up
// - Busy high during suspend or resume cycle
// - Opcode 01h needs write unlock latch set
// - Write leaves main bits 1,0 untouched
// - Select rise off byte boundary discards write
// - Select rise starts timed write; busy meanwhile
// - Write unlock latch cleared at write end
// - Write updates region guard and lock bits
// - Pin locked mode refuses every write
// - Both commands also work in four-wire mode
// - Lock bit plus low pin gives lock mode
// - Opcode 06h sets write unlock latch
`timescale 1ns/1ps
module fsra_core #(
  parameter int T_W_CYC    = fsra_pkg::FSRA_T_W_CYC,
  parameter int T_SUSP_CYC = fsra_pkg::FSRA_T_SUSP_CYC
) (
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       sw_reset_in,
  input  wire logic       chip_sel_n_in,
  input  wire logic       sclk_in,
  input  wire logic [3:0] dq_in,
  output logic      [3:0] dq_out,
  output logic      [3:0] dq_oe_out,
  input  wire logic       write_protect_n_in,
  input  wire logic       suspend_req_in,
  input  wire logic       resume_req_in,
  input  wire logic       erase_active_in,
  input  wire logic       prog_active_in,
  input  wire logic       array_start_in,
  input  wire logic       array_fail_in,
  input  wire logic       array_busy_in,
  input  wire logic       unlock_clear_in,
  output logic      [7:0] main_status_out,
  output logic      [7:0] suspend_status_out,
  output logic            pin_locked_mode_out
);
  // Two-stage synchronisers for pins
  logic [5:0] s1, s2;
  logic       sclk_d, cs_d;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1 <= 6'h21;
      s2 <= 6'h21;
    end else begin
      s1 <= {chip_sel_n_in, sclk_in, dq_in};
      s2 <= s1;
    end
  end
  wire logic       cs_n   = s2[5];
  wire logic       sclk   = s2[4];
  wire logic [3:0] dq     = s2[3:0];
  wire logic       wp_n_s;
  logic [1:0]      wp_sync;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) wp_sync <= 2'b11;
    else wp_sync <= {wp_sync[0], write_protect_n_in};
  end
  assign wp_n_s = wp_sync[1];

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      sclk_d <= sclk;
      cs_d   <= cs_n;
    end
  end
  wire logic rise    = sclk & ~sclk_d & ~cs_n;
  wire logic fall    = ~sclk & sclk_d & ~cs_n;
  wire logic cs_rise = cs_n & ~cs_d;

  // State
  fsra_pkg::fsra_phase_t phase;
  fsra_pkg::fsra_flags_t flg;
  logic       four_wire;
  logic [7:0] shin;
  logic [3:0] bitcnt;
  logic [7:0] shout;
  logic [7:0] wr_data;
  logic       wr_ok;
  logic [4:0] main_nv;
  logic       w_run, w_done, s_run;
  logic [7:0] susp_word;

  wire logic locked = main_nv[4] & ~wp_n_s;
  assign pin_locked_mode_out = locked;
  // Done cycle counts as busy so a poll never sees stale guard bits
  wire logic busy = w_run | w_done | s_run | array_busy_in;

  function automatic logic [7:0] shift_in(input logic [7:0] cur,
                                           input logic [3:0] d,
                                           input logic       quad);
    shift_in = quad ? {cur[3:0], d} : {cur[6:0], d[0]};
  endfunction

  // Reserved bits 6, 4 and 0 stay zero
  always_comb begin
    susp_word = 8'h00;
    susp_word[fsra_pkg::FSRA_SS_BUSY]  = busy;
    susp_word[fsra_pkg::FSRA_SS_FAIL]  = flg.fail;
    susp_word[fsra_pkg::FSRA_SS_PROG]  = flg.prog_paused;
    susp_word[fsra_pkg::FSRA_SS_ERASE] = flg.erase_paused;
    susp_word[fsra_pkg::FSRA_SS_UNLK]  = flg.unlock;
  end
  assign suspend_status_out = susp_word;
  assign main_status_out = {main_nv[4], 1'b0, main_nv[3:0], 2'b00}
                         | {6'h00, flg.unlock, busy};

  wire logic [7:0] next_shin = shift_in(shin, dq, four_wire);
  wire logic [3:0] step      = four_wire ? 4'h4 : 4'h1;
  wire logic       byte_done = rise && ((bitcnt + step) == 4'h8);

  // Frame decoder
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase   <= fsra_pkg::FSRA_OP_IDLE;
      shin    <= 8'h00;
      bitcnt  <= 4'h0;
      wr_data <= 8'h00;
      wr_ok   <= 1'b0;
    end else if (cs_n) begin
      phase  <= fsra_pkg::FSRA_OP_CMD;
      bitcnt <= 4'h0;
      wr_ok  <= 1'b0;
    end else begin
      case (phase)
        fsra_pkg::FSRA_OP_CMD: begin
          if (rise) begin
            shin   <= next_shin;
            bitcnt <= byte_done ? 4'h0 : bitcnt + step;
            if (byte_done) begin
              if (next_shin == fsra_pkg::FSRA_OP_READ_SUSPEND)
                phase <= fsra_pkg::FSRA_OP_RDSUS;
              else if (next_shin == fsra_pkg::FSRA_OP_WRITE_MAIN &&
                       flg.unlock && !locked && !busy)
                phase <= fsra_pkg::FSRA_OP_WRDATA;
              else
                phase <= fsra_pkg::FSRA_OP_IDLE;
            end
          end
        end
        fsra_pkg::FSRA_OP_WRDATA: begin
          if (rise) begin
            shin   <= next_shin;
            bitcnt <= byte_done ? 4'h0 : bitcnt + step;
            if (byte_done) begin
              wr_data <= next_shin;
              wr_ok   <= 1'b1;
            end else begin
              wr_ok   <= 1'b0;
            end
          end
        end
        fsra_pkg::FSRA_OP_RDSUS: phase <= fsra_pkg::FSRA_OP_RDSUS;
        fsra_pkg::FSRA_OP_IDLE:  phase <= fsra_pkg::FSRA_OP_IDLE;
        default:                 phase <= fsra_pkg::FSRA_OP_IDLE;
      endcase
    end
  end

  // One-byte opcodes acted on at select rise
  wire logic op_end  = cs_rise && phase == fsra_pkg::FSRA_OP_IDLE
                       && bitcnt == 4'h0;
  wire logic wr_go   = cs_rise && wr_ok
                       && phase == fsra_pkg::FSRA_OP_WRDATA;

  // Four-wire mode entry and exit
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      four_wire <= 1'b0;
    end else if (sw_reset_in) begin
      four_wire <= 1'b0;
    end else if (op_end && shin == fsra_pkg::FSRA_OP_FOUR_WIRE) begin
      four_wire <= 1'b1;
    end else if (op_end && shin == fsra_pkg::FSRA_OP_LEAVE_FOUR) begin
      four_wire <= 1'b0;
    end
  end

  // Bit counter within each output byte, for repetition
  logic [2:0] obits;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      obits <= 3'h0;
    end else if (cs_n || phase != fsra_pkg::FSRA_OP_RDSUS) begin
      obits <= 3'h0;
    end else if (fall) begin
      obits <= obits + (four_wire ? 3'h4 : 3'h1);
    end
  end
  wire logic reload = fall && (four_wire ? obits[2] : obits == 3'h7);

  // Status output shifter, repeating the byte while selected
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shout     <= 8'h00;
      dq_out    <= 4'h0;
      dq_oe_out <= 4'h0;
    end else if (cs_n || phase != fsra_pkg::FSRA_OP_RDSUS) begin
      shout     <= susp_word;
      dq_oe_out <= 4'h0;
      dq_out    <= 4'h0;
    end else if (fall) begin
      if (four_wire) begin
        dq_out    <= shout[7:4];
        dq_oe_out <= 4'hF;
      end else begin
        dq_out    <= {2'b00, shout[7], 1'b0};
        dq_oe_out <= 4'h2;
      end
      // Fresh flags each byte, so a long poll sees busy drop
      if (reload)
        shout <= susp_word;
      else if (four_wire)
        shout <= {shout[3:0], 4'h0};
      else
        shout <= {shout[6:0], 1'b0};
    end
  end

  // Nonvolatile guard and lock bits
  fsra_timer #(.W(16)) u_wtimer (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .start_in   (wr_go),
    .len_in     (16'(T_W_CYC)),
    .run_out    (w_run),
    .done_out   (w_done)
  );
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      main_nv <= fsra_pkg::FSRA_MAIN_RESET[4:0];
    end else if (w_done) begin
      main_nv <= {wr_data[fsra_pkg::FSRA_MS_LOCK],
                  wr_data[fsra_pkg::FSRA_MS_GUARD+3:
                          fsra_pkg::FSRA_MS_GUARD]};
    end
  end

  // Suspend and resume cycles
  wire logic sus_go = (suspend_req_in | resume_req_in) & flg.unlock
                      & ~s_run;
  fsra_timer #(.W(16)) u_stimer (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .start_in   (sus_go),
    .len_in     (16'(T_SUSP_CYC)),
    .run_out    (s_run),
    .done_out   ()
  );

  // Volatile flags, all zero at power up
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flg <= '0;
    end else if (sw_reset_in) begin
      flg <= '0;
    end else begin
      if (op_end && shin == fsra_pkg::FSRA_OP_WRITE_UNLOCK)
        flg.unlock <= 1'b1;
      else if (w_done || unlock_clear_in)
        flg.unlock <= 1'b0;
      if (array_fail_in)
        flg.fail <= 1'b1;
      else if (array_start_in)
        flg.fail <= 1'b0;
      if (sus_go && suspend_req_in && erase_active_in)
        flg.erase_paused <= 1'b1;
      else if (sus_go && resume_req_in)
        flg.erase_paused <= 1'b0;
      if (sus_go && suspend_req_in && prog_active_in)
        flg.prog_paused <= 1'b1;
      else if (sus_go && resume_req_in)
        flg.prog_paused <= 1'b0;
    end
  end

  a_ss_busy_write: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) wr_go |=> suspend_status_out[7] [*8])
    else $error("busy not high during write cycle");
  a_busy_write: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) wr_go |=> main_status_out[0] [*8])
    else $error("main busy not high during write cycle");
  a_reserved: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) (suspend_status_out & 8'h51) == 8'h00)
    else $error("reserved suspend bit set");
  a_busy_mirror: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) suspend_status_out[7] == main_status_out[0])
    else $error("busy copies differ");
  a_unlock_end: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) w_done |=> !suspend_status_out[1])
    else $error("unlock latch not cleared");
  a_no_write_locked: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (phase == fsra_pkg::FSRA_OP_CMD && byte_done && locked)
      |=> phase != fsra_pkg::FSRA_OP_WRDATA)
    else $error("write accepted in locked mode");
  a_need_unlock: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (phase == fsra_pkg::FSRA_OP_CMD && byte_done && !flg.unlock)
      |=> phase != fsra_pkg::FSRA_OP_WRDATA)
    else $error("write accepted without unlock");
  a_fail_hold: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (flg.fail && !array_start_in && !sw_reset_in) |=> flg.fail)
    else $error("fail flag dropped");
  a_susp_busy: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) sus_go |=> suspend_status_out[7] [*4])
    else $error("busy low during suspend cycle");
  a_erase_flag: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (sus_go && resume_req_in && !suspend_req_in) |=> !flg.erase_paused)
    else $error("erase flag not cleared on resume");
  a_prog_flag: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (sus_go && suspend_req_in && prog_active_in && !sw_reset_in)
      |=> flg.prog_paused)
    else $error("program flag not set on suspend");
  a_repeat: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) reload |=> shout == $past(susp_word))
    else $error("status byte not reloaded for repeat");
  a_release: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) cs_n |=> dq_oe_out == 4'h0)
    else $error("data pins driven while deselected");
  a_four_wire: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    (op_end && !sw_reset_in && shin == fsra_pkg::FSRA_OP_FOUR_WIRE)
      |=> four_wire)
    else $error("four wire mode not entered");
  a_guard_land: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in)
    w_done |=> main_status_out[5:2] == $past(wr_data[5:2]))
    else $error("guard bits not written");
endmodule

// *** logic/fsra_timer.sv ***
// Self-timed cycle counter that pulses done at the end of a run
`timescale 1ns/1ps
module fsra_timer #(
  parameter int W = 16
) (
  input  wire logic         ref_clk_in,
  input  wire logic         nrst_in,
  input  wire logic         start_in,
  input  wire logic [W-1:0] len_in,
  output logic              run_out,
  output logic              done_out
);
  logic [W-1:0] cnt;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt      <= '0;
      run_out  <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt     <= len_in;
        run_out <= 1'b1;
      end else if (run_out) begin
        if (cnt <= 1) begin
          run_out  <= 1'b0;
          done_out <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end
endmodule

// *** verification/fsra_host.sv ***
// Behavioural serial host model that drives frames at the flash pins
`timescale 1ns/1ps
module fsra_host (
  input  wire logic [3:0] dq_in,
  input  wire logic       ref_clk_in,
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic      [3:0] dq_out
);
  // Half period in reference clocks; raised to model a slow host
  int half = 4;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    dq_out   = 4'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Released lines toggle so a stale level is never mistaken for data
  task automatic shift(input logic [15:0] tx, input int n, input bit q,
                       input bit rd, inout logic [15:0] rx);
    for (int i = 0; i < n; i++) begin
      if (rd) dq_out = ~dq_out;
      else if (q) dq_out = tx[15:12];
      else dq_out = {~dq_out[3:1], tx[15]};
      tick(half);
      sclk_out = 1'b1;
      tick(half);
      rx = q ? {rx[11:0], dq_in} : {rx[14:0], dq_in[1]};
      sclk_out = 1'b0;
      tx = q ? tx << 4 : tx << 1;
    end
  endtask
  task automatic frame(input logic [7:0] op, input logic [15:0] tx,
                       input int n, input bit rd, input bit q,
                       output logic [15:0] rx);
    rx = 16'h0000;
    cs_n_out = 1'b0;
    tick(half);
    shift({op, 8'h00}, q ? 2 : 8, q, 1'b0, rx);
    shift(tx, n, q, rd, rx);
    tick(half);
    cs_n_out = 1'b1;
    dq_out = ~dq_out;
    tick(8);
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the status register access engine
`timescale 1ns/1ps
module tb;
  localparam int TW = 20;
  localparam int TS = 8;
  logic        ref_clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        sw_rst = 1'b0;
  logic        wp_n = 1'b1;
  logic        er = 1'b0;
  logic        pr = 1'b0;
  logic        abusy = 1'b0;
  logic [4:0]  pls = 5'h00;
  logic        cs_n;
  logic        sclk;
  logic [3:0]  h_dq;
  logic [3:0]  d_dq;
  logic [3:0]  d_oe;
  logic [3:0]  dq_w;
  logic [7:0]  ms;
  logic [7:0]  ss;
  logic        plm;
  logic [15:0] lfsr = 16'hE796;
  logic [15:0] rx;
  logic [7:0]  d;
  logic [7:0]  e;
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  assign dq_w = (d_oe & d_dq) | (~d_oe & h_dq);
  fsra_core #(.T_W_CYC(TW), .T_SUSP_CYC(TS)) dut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sw_reset_in(sw_rst),
    .chip_sel_n_in(cs_n), .sclk_in(sclk), .dq_in(dq_w), .dq_out(d_dq),
    .dq_oe_out(d_oe), .write_protect_n_in(wp_n),
    .suspend_req_in(pls[0]), .resume_req_in(pls[1]),
    .erase_active_in(er), .prog_active_in(pr),
    .array_start_in(pls[2]), .array_fail_in(pls[3]),
    .array_busy_in(abusy), .unlock_clear_in(pls[4]),
    .main_status_out(ms), .suspend_status_out(ss),
    .pin_locked_mode_out(plm));
  fsra_host host (.dq_in(dq_w), .ref_clk_in(ref_clk_in), .cs_n_out(cs_n),
    .sclk_out(sclk), .dq_out(h_dq));
  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic pulse(input logic [4:0] m);
    @(negedge ref_clk_in) pls = m;
    @(negedge ref_clk_in) pls = 5'h00;
    tick(4);
  endtask
  // Host waits for the busy flag to drop before its next instruction
  task automatic wait_idle;
    int n;
    n = 0;
    while (ms[0] !== 1'b0 && n < 2000) begin
      tick(1);
      n++;
    end
    if (n == 2000) chk("busy_timeout", 8'h00, 8'h01);
  endtask
  task automatic write_unlock_cmd(input bit q);
    host.frame(fsra_pkg::FSRA_OP_WRITE_UNLOCK, 16'h0000, 0, 0, q, rx);
  endtask
  task automatic write_main_flags_cmd(input logic [15:0] v, input int n, input bit q);
    host.frame(fsra_pkg::FSRA_OP_WRITE_MAIN, v, n, 0, q, rx);
  endtask
  always @(negedge ref_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      report_and_stop();
    end
    if (nrst_in) begin
      chk("busy_mirror", {7'h00, ms[0]}, {7'h00, ss[7]});
      chk("reserved", 8'h00, ss & 8'h51);
    end
  end
  initial begin
    tick(16);
    nrst_in = 1'b1;
    tick(4);
    chk("main_reset", 8'h00, ms);
    chk("susp_reset", 8'h00, ss);
    write_main_flags_cmd(16'hBC00, 8, 0);
    tick(TW + 8);
    chk("main_no_latch", 8'h00, ms);
    $display("test reset and refusal done");
    for (int k = 0; k < 4; k++) begin
      lfsr = next_rand(lfsr);
      d = lfsr[7:0] | 8'h03;
      write_unlock_cmd(0);
      chk("unlock_set", 8'h02, ms & 8'h03);
      chk("susp_unlock", 8'h02, ss & 8'h02);
      write_main_flags_cmd({d, 8'h00}, 8, 0);
      chk("busy_during", 8'h01, ms & 8'h01);
      wait_idle();
      chk("main_written", d & 8'hBC, ms);
      e = d & 8'hBC;
    end
    for (int n = 7; n <= 9; n += 2) begin
      write_unlock_cmd(0);
      write_main_flags_cmd({~e, 8'h80}, n, 0);
      tick(TW + 8);
      chk("frame_length", e, ms & 8'hFC);
    end
    $display("test main writes done");
    write_unlock_cmd(0);
    write_main_flags_cmd(16'h8000, 8, 0);
    wait_idle();
    wp_n = 1'b0;
    tick(4);
    chk("locked", 8'h01, {7'h00, plm});
    write_unlock_cmd(0);
    write_main_flags_cmd(16'h3C00, 8, 0);
    tick(TW + 8);
    chk("locked_refuse", 8'h80, ms & 8'hFC);
    wp_n = 1'b1;
    tick(4);
    chk("unlocked", 8'h00, {7'h00, plm});
    write_unlock_cmd(0);
    write_main_flags_cmd(16'h0000, 8, 0);
    wait_idle();
    chk("lock_cleared", 8'h00, ms);
    $display("test pin lock done");
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'h08 : 8'h04;
      er = (k == 0);
      pr = (k == 1);
      pulse(5'h10);
      pulse(5'h01);
      tick(TS + 4);
      chk("susp_refused", 8'h00, ss & 8'h0C);
      write_unlock_cmd(0);
      @(negedge ref_clk_in) pls = 5'h01;
      @(negedge ref_clk_in) pls = 5'h00;
      tick(2);
      chk("susp_busy", 8'h80, ss & 8'h80);
      tick(TS + 4);
      chk("susp_done", d, ss & 8'h8C);
      host.frame(fsra_pkg::FSRA_OP_READ_SUSPEND, 16'h0000, 16, 1, 0, rx);
      chk("read_first", d, rx[15:8] & 8'hAC);
      chk("read_again", d, rx[7:0] & 8'hAC);
      write_unlock_cmd(0);
      pulse(5'h02);
      tick(TS + 4);
      chk("resumed", 8'h00, ss & 8'h8C);
      er = 1'b0;
      pr = 1'b0;
    end
    $display("test suspend flags done");
    pulse(5'h08);
    chk("fail_set", 8'h20, ss & 8'h20);
    tick(20);
    chk("fail_held", 8'h20, ss & 8'h20);
    pulse(5'h04);
    chk("fail_start", 8'h00, ss & 8'h20);
    pulse(5'h08);
    @(negedge ref_clk_in) sw_rst = 1'b1;
    @(negedge ref_clk_in) sw_rst = 1'b0;
    tick(2);
    chk("fail_swreset", 8'h00, ss & 8'h20);
    abusy = 1'b1;
    tick(3);
    chk("array_busy", 8'h80, ss & 8'h80);
    abusy = 1'b0;
    tick(3);
    $display("test fail flag done");
    host.frame(fsra_pkg::FSRA_OP_FOUR_WIRE, 16'h0000, 0, 0, 0, rx);
    write_unlock_cmd(1);
    host.frame(fsra_pkg::FSRA_OP_READ_SUSPEND, 16'h0000, 4, 1, 1, rx);
    chk("quad_read", 8'h02, rx[15:8] & 8'hAE);
    chk("quad_read_again", 8'h02, rx[7:0] & 8'hAE);
    host.half = 12;
    write_main_flags_cmd(16'h2400, 2, 1);
    host.half = 4;
    wait_idle();
    chk("quad_write", 8'h24, ms);
    host.frame(fsra_pkg::FSRA_OP_LEAVE_FOUR, 16'h0000, 0, 0, 1, rx);
    write_unlock_cmd(0);
    host.frame(fsra_pkg::FSRA_OP_READ_SUSPEND, 16'h0000, 16, 1, 0, rx);
    chk("single_again", 8'h02, rx[15:8] & 8'hAE);
    $display("test four wire done");
    report_and_stop();
  end
endmodule
